// ==== verilog/dual_mode_timer_counters.v ====
// three 16-bit timer/counters, mode select and pin gating on units 0 and 1 only, and special register access
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"

module dual_mode_timer_counters (
  // clock and reset
  input  wire       ref_clk_i,
  input  wire       rst_i,
  // special function register port
  input  wire [7:0] sfr_addr_i,
  input  wire       sfr_wr_i,
  input  wire [7:0] sfr_wdata_i,
  output wire [7:0] sfr_rdata_o,
  // service routine vector acknowledge from the core
  input  wire       unit0_vector_ack_i,
  input  wire       unit1_vector_ack_i,
  // external pins
  input  wire       unit0_count_pin_i,
  input  wire       unit1_count_pin_i,
  input  wire       unit2_count_pin_i,
  input  wire       ext_irq0_pin_i,
  input  wire       ext_irq1_pin_i,
  // overflow flags toward the interrupt logic
  output wire       unit0_overflow_flag_o,
  output wire       unit1_overflow_flag_o,
  output wire       unit2_overflow_flag_o
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  reg  [7:0] unit0_count_low_ff;
  reg  [7:0] unit0_count_high_ff;
  reg  [7:0] unit1_count_low_ff;
  reg  [7:0] unit1_count_high_ff;
  reg  [7:0] unit2_count_low_ff;
  reg  [7:0] unit2_count_high_ff;
  reg  [7:0] unit2_reload_low_ff;
  reg  [7:0] unit2_reload_high_ff;
  reg  [7:0] timer_mode_select_ff;
  reg  [7:0] timer_ctrl_a_ff;
  reg  [7:0] unit2_control_ff;
  reg  [7:0] rdata_ff;

  reg  [7:0] nxt_unit0_count_low;
  reg  [7:0] nxt_unit0_count_high;
  reg  [7:0] nxt_unit1_count_low;
  reg  [7:0] nxt_unit1_count_high;
  reg  [7:0] nxt_unit2_count_low;
  reg  [7:0] nxt_unit2_count_high;
  reg  [7:0] nxt_timer_ctrl_a;
  reg  [7:0] nxt_unit2_control;
  reg  [7:0] nxt_rdata;
  reg [16:0] unit0_step;
  reg [16:0] unit1_step;
  reg  [7:0] split_high;
  reg        split_ovf;
  reg [15:0] unit2_sum;
  reg        unit2_ovf;

  wire [4:0] pin_level;
  wire [4:0] pin_fall;

  //////////////////////////////////////////////////////////////////////////////
  // pin sampling: bit 0..2 count pins, bit 3..4 interrupt pins

  pin_edge_sampler #(
    .WIDTH (5)
  ) u_pins (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pin_i     ({ext_irq1_pin_i, ext_irq0_pin_i, unit2_count_pin_i,
                 unit1_count_pin_i, unit0_count_pin_i}),
    .level_o   (pin_level),
    .fall_o    (pin_fall)
  );

  //////////////////////////////////////////////////////////////////////////////
  // field decode

  wire [1:0] unit0_mode_field = timer_mode_select_ff[`TMR_MODE_U0_FIELD_HI:`TMR_MODE_U0_FIELD_LO];
  wire [1:0] unit1_mode_field = timer_mode_select_ff[`TMR_MODE_U1_FIELD_HI:`TMR_MODE_U1_FIELD_LO];
  wire       unit0_pin_gate      = timer_mode_select_ff[`TMR_MODE_U0_GATE];
  wire       unit1_pin_gate      = timer_mode_select_ff[`TMR_MODE_U1_GATE];
  wire       unit0_source_select = timer_mode_select_ff[`TMR_MODE_U0_SOURCE];
  wire       unit1_source_select = timer_mode_select_ff[`TMR_MODE_U1_SOURCE];
  wire       unit0_run           = timer_ctrl_a_ff[`TMR_CTRL_U0_RUN];
  wire       unit1_run           = timer_ctrl_a_ff[`TMR_CTRL_U1_RUN];
  wire       unit2_run           = unit2_control_ff[`TMR_U2_RUN];
  wire       unit2_source_select = unit2_control_ff[`TMR_U2_SOURCE];

  // gate: pin must be high as well as run bit
  wire unit0_enable = unit0_run & (~unit0_pin_gate | pin_level[3]);
  wire unit1_enable = unit1_run & (~unit1_pin_gate | pin_level[4]);

  // count event: every cycle as timer, a sampled falling edge as counter
  wire unit0_tick = unit0_enable & (unit0_source_select ? pin_fall[0] : 1'b1);
  wire unit1_tick = unit1_enable & (unit1_source_select ? pin_fall[1] : 1'b1);
  wire unit2_tick = unit2_run & (unit2_source_select ? pin_fall[2] : 1'b1);

  // register write strobes
  wire wr_ctrl_a  = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_CTRL_A);
  wire wr_mode    = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_MODE_SELECT);
  wire wr_u0_low  = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_U0_LOW);
  wire wr_u1_low  = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_U1_LOW);
  wire wr_u0_high = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_U0_HIGH);
  wire wr_u1_high = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_U1_HIGH);
  wire wr_u2_ctrl = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_U2_CONTROL);
  wire wr_u2_rl   = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_U2_RELOAD_LOW);
  wire wr_u2_rh   = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_U2_RELOAD_HI);
  wire wr_u2_low  = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_U2_LOW);
  wire wr_u2_high = sfr_wr_i & (sfr_addr_i == `TMR_ADDR_U2_HIGH);

  //////////////////////////////////////////////////////////////////////////////
  // one count step for modes 00, 01, 10; returns {overflow, high, low}

  function [16:0] count_step;
    input [1:0] mode;
    input [7:0] low;
    input [7:0] high;
    input       tick;
    begin
      count_step = {1'b0, high, low};
      if (tick) begin
        case (mode)
          `TMR_MODE_PRESCALED: begin
            // upper three low-byte bits are left alone
            if (low[4:0] == `TMR_PRESCALE_TOP) begin
              count_step = {(high == 8'hff), high + 8'h01, low[7:5], 5'h00};
            end else begin
              count_step = {1'b0, high, low[7:5], low[4:0] + 5'h01};
            end
          end
          `TMR_MODE_CASCADED: begin
            count_step = {({high, low} == 16'hffff), {high, low} + 16'h0001};
          end
          `TMR_MODE_AUTORELOAD: begin
            if (low == 8'hff) begin
              count_step = {1'b1, high, high};
            end else begin
              count_step = {1'b0, high, low + 8'h01};
            end
          end
          default: begin
            count_step = {1'b0, high, low};
          end
        endcase
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next-state of the counters; a software write wins over counting

  always @* begin
    unit0_step = count_step(unit0_mode_field, unit0_count_low_ff, unit0_count_high_ff,
                            unit0_tick);
    unit1_step = count_step(unit1_mode_field, unit1_count_low_ff, unit1_count_high_ff,
                            unit1_tick);
    split_high = unit0_count_high_ff;
    split_ovf  = 1'b0;
    if (unit0_mode_field == `TMR_MODE_SPLIT) begin
      // low byte on unit-0 controls and source
      unit0_step[16] = unit0_tick & (unit0_count_low_ff == 8'hff);
      unit0_step[7:0] = unit0_count_low_ff + {7'h00, unit0_tick};
      unit0_step[15:8] = unit0_count_high_ff;
      // high byte always counts clocks, gated only by the unit-1 run bit
      if (unit1_run) begin
        split_high = unit0_count_high_ff + 8'h01;
        split_ovf  = (unit0_count_high_ff == 8'hff);
      end
    end
    if (unit1_mode_field == `TMR_MODE_SPLIT) begin
      unit1_step = {1'b0, unit1_count_high_ff, unit1_count_low_ff};
    end
    nxt_unit0_count_low  = wr_u0_low  ? sfr_wdata_i : unit0_step[7:0];
    nxt_unit0_count_high = wr_u0_high ? sfr_wdata_i :
                           ((unit0_mode_field == `TMR_MODE_SPLIT) ? split_high
                                                                  : unit0_step[15:8]);
    nxt_unit1_count_low  = wr_u1_low  ? sfr_wdata_i : unit1_step[7:0];
    nxt_unit1_count_high = wr_u1_high ? sfr_wdata_i : unit1_step[15:8];
  end

  // unit 2: plain 16-bit counter reloaded from its reload pair on wrap
  always @* begin
    unit2_sum = {unit2_count_high_ff, unit2_count_low_ff};
    unit2_ovf = 1'b0;
    if (unit2_tick) begin
      if ({unit2_count_high_ff, unit2_count_low_ff} == 16'hffff) begin
        unit2_sum = {unit2_reload_high_ff, unit2_reload_low_ff};
        unit2_ovf = 1'b1;
      end else begin
        unit2_sum = {unit2_count_high_ff, unit2_count_low_ff} + 16'h0001;
      end
    end
    nxt_unit2_count_low  = wr_u2_low  ? sfr_wdata_i : unit2_sum[7:0];
    nxt_unit2_count_high = wr_u2_high ? sfr_wdata_i : unit2_sum[15:8];
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers: hardware set of a flag wins over any clear

  wire unit0_set = unit0_step[16];
  // in split mode the high byte of unit 0 owns the unit-1 flag
  wire unit1_set = (unit0_mode_field == `TMR_MODE_SPLIT) ? split_ovf : unit1_step[16];

  always @* begin
    nxt_timer_ctrl_a = wr_ctrl_a ? sfr_wdata_i : timer_ctrl_a_ff;
    if (unit0_vector_ack_i) begin
      nxt_timer_ctrl_a[`TMR_CTRL_U0_FLAG] = 1'b0;
    end
    if (unit1_vector_ack_i) begin
      nxt_timer_ctrl_a[`TMR_CTRL_U1_FLAG] = 1'b0;
    end
    if (unit0_set) begin
      nxt_timer_ctrl_a[`TMR_CTRL_U0_FLAG] = 1'b1;
    end
    if (unit1_set) begin
      nxt_timer_ctrl_a[`TMR_CTRL_U1_FLAG] = 1'b1;
    end
    nxt_unit2_control = wr_u2_ctrl ? sfr_wdata_i : unit2_control_ff;
    if (unit2_ovf) begin
      nxt_unit2_control[`TMR_U2_FLAG] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux, registered; unmapped addresses read zero

  always @* begin
    case (sfr_addr_i)
      `TMR_ADDR_CTRL_A:        nxt_rdata = timer_ctrl_a_ff;
      `TMR_ADDR_MODE_SELECT:   nxt_rdata = timer_mode_select_ff;
      `TMR_ADDR_U0_LOW:        nxt_rdata = unit0_count_low_ff;
      `TMR_ADDR_U1_LOW:        nxt_rdata = unit1_count_low_ff;
      `TMR_ADDR_U0_HIGH:       nxt_rdata = unit0_count_high_ff;
      `TMR_ADDR_U1_HIGH:       nxt_rdata = unit1_count_high_ff;
      `TMR_ADDR_U2_CONTROL:    nxt_rdata = unit2_control_ff;
      `TMR_ADDR_U2_RELOAD_LOW: nxt_rdata = unit2_reload_low_ff;
      `TMR_ADDR_U2_RELOAD_HI:  nxt_rdata = unit2_reload_high_ff;
      `TMR_ADDR_U2_LOW:        nxt_rdata = unit2_count_low_ff;
      `TMR_ADDR_U2_HIGH:       nxt_rdata = unit2_count_high_ff;
      default:                 nxt_rdata = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // register update

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      unit0_count_low_ff   <= `TMR_RST_BYTE;
      unit0_count_high_ff  <= `TMR_RST_BYTE;
      unit1_count_low_ff   <= `TMR_RST_BYTE;
      unit1_count_high_ff  <= `TMR_RST_BYTE;
      unit2_count_low_ff   <= `TMR_RST_BYTE;
      unit2_count_high_ff  <= `TMR_RST_BYTE;
      unit2_reload_low_ff  <= `TMR_RST_BYTE;
      unit2_reload_high_ff <= `TMR_RST_BYTE;
      timer_mode_select_ff <= `TMR_RST_MODE_SELECT;
      timer_ctrl_a_ff      <= `TMR_RST_CTRL;
      unit2_control_ff     <= `TMR_RST_CTRL;
      rdata_ff             <= 8'h00;
    end else begin
      unit0_count_low_ff   <= nxt_unit0_count_low;
      unit0_count_high_ff  <= nxt_unit0_count_high;
      unit1_count_low_ff   <= nxt_unit1_count_low;
      unit1_count_high_ff  <= nxt_unit1_count_high;
      unit2_count_low_ff   <= nxt_unit2_count_low;
      unit2_count_high_ff  <= nxt_unit2_count_high;
      if (wr_u2_rl) begin
        unit2_reload_low_ff <= sfr_wdata_i;
      end
      if (wr_u2_rh) begin
        unit2_reload_high_ff <= sfr_wdata_i;
      end
      if (wr_mode) begin
        timer_mode_select_ff <= sfr_wdata_i;
      end
      timer_ctrl_a_ff      <= nxt_timer_ctrl_a;
      unit2_control_ff     <= nxt_unit2_control;
      rdata_ff             <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign sfr_rdata_o           = rdata_ff;
  assign unit0_overflow_flag_o = timer_ctrl_a_ff[`TMR_CTRL_U0_FLAG];
  assign unit1_overflow_flag_o = timer_ctrl_a_ff[`TMR_CTRL_U1_FLAG];
  assign unit2_overflow_flag_o = unit2_control_ff[`TMR_U2_FLAG];

endmodule

`default_nettype wire

// ==== shared/timer_consts.vh ====
// offsets, field positions, encodings and reset values of the timer/counter block
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// special function register addresses
`define TMR_ADDR_CTRL_A        8'h88
`define TMR_ADDR_MODE_SELECT   8'h89
`define TMR_ADDR_U0_LOW        8'h8a
`define TMR_ADDR_U1_LOW        8'h8b
`define TMR_ADDR_U0_HIGH       8'h8c
`define TMR_ADDR_U1_HIGH       8'h8d
`define TMR_ADDR_U2_CONTROL    8'hc8
`define TMR_ADDR_U2_RELOAD_LOW 8'hca
`define TMR_ADDR_U2_RELOAD_HI  8'hcb
`define TMR_ADDR_U2_LOW        8'hcc
`define TMR_ADDR_U2_HIGH       8'hcd

// timer_ctrl_a fields
`define TMR_CTRL_U1_FLAG       7
`define TMR_CTRL_U1_RUN        6
`define TMR_CTRL_U0_FLAG       5
`define TMR_CTRL_U0_RUN        4

// timer_mode_select fields
`define TMR_MODE_U1_GATE       7
`define TMR_MODE_U1_SOURCE     6
`define TMR_MODE_U1_FIELD_HI   5
`define TMR_MODE_U1_FIELD_LO   4
`define TMR_MODE_U0_GATE       3
`define TMR_MODE_U0_SOURCE     2
`define TMR_MODE_U0_FIELD_HI   1
`define TMR_MODE_U0_FIELD_LO   0

// unit2_control fields
`define TMR_U2_FLAG            7
`define TMR_U2_RUN             2
`define TMR_U2_SOURCE          1

// mode field encodings
`define TMR_MODE_PRESCALED     2'b00
`define TMR_MODE_CASCADED      2'b01
`define TMR_MODE_AUTORELOAD    2'b10
`define TMR_MODE_SPLIT         2'b11

// prescaler terminal value in the 13-bit mode
`define TMR_PRESCALE_TOP       5'h1f

// reset values
`define TMR_RST_BYTE           8'h00
`define TMR_RST_MODE_SELECT    8'h00
`define TMR_RST_CTRL           8'h00

`endif

// ==== verilog/pin_edge_sampler.v ====
// two-stage synchroniser per pin with one extra sample for falling-edge detection
`timescale 1ns/1ps
`default_nettype none

module pin_edge_sampler #(
  parameter WIDTH = 5
) (
  // clock and reset
  input  wire             ref_clk_i,
  input  wire             rst_i,
  // raw pins
  input  wire [WIDTH-1:0] pin_i,
  // synchronised level and falling-edge pulse
  output wire [WIDTH-1:0] level_o,
  output wire [WIDTH-1:0] fall_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : gen_pin
      reg meta_ff;
      reg sync_ff;
      reg prev_ff;

      // meta_ff is read by sync_ff only
      always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          prev_ff <= 1'b0;
        end else begin
          meta_ff <= pin_i[g];
          sync_ff <= meta_ff;
          prev_ff <= sync_ff;
        end
      end

      assign level_o[g] = sync_ff;
      // high sample followed by low sample: two cycles per edge at best
      assign fall_o[g]  = prev_ff & ~sync_ff;
    end
  endgenerate

endmodule

`default_nettype wire

// ==== dv/timer_properties.sv ====
// concurrent checks on the register port and overflow flags of the timer block
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"

module timer_properties (
  // clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  // register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // vector acknowledge
  input wire logic       unit0_vector_ack_i,
  input wire logic       unit1_vector_ack_i,
  // pins
  input wire logic       unit0_count_pin_i,
  input wire logic       unit1_count_pin_i,
  input wire logic       unit2_count_pin_i,
  input wire logic       ext_irq0_pin_i,
  input wire logic       ext_irq1_pin_i,
  // flags
  input wire logic       unit0_overflow_flag_o,
  input wire logic       unit1_overflow_flag_o,
  input wire logic       unit2_overflow_flag_o
);
  // decode of the register map; 0xc9 is a hole inside the unit-2 group
  wire mapped  = (sfr_addr_i >= 8'h88 && sfr_addr_i <= 8'h8d) || sfr_addr_i == 8'hc8
               || (sfr_addr_i >= 8'hca && sfr_addr_i <= 8'hcd);
  wire wr_ctrl = sfr_wr_i && sfr_addr_i == `TMR_ADDR_CTRL_A;
  wire wr_u2   = sfr_wr_i && sfr_addr_i == `TMR_ADDR_U2_CONTROL;
  wire rd_ctrl = !sfr_wr_i && sfr_addr_i == `TMR_ADDR_CTRL_A;
  wire rd_u2   = !sfr_wr_i && sfr_addr_i == `TMR_ADDR_U2_CONTROL;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_unmapped_reads_zero: assert property (!$past(mapped) |-> sfr_rdata_o == 8'h00)
    else $error("unmapped address gave nonzero read data");
  a_mode_write_back: assert property ((sfr_wr_i && sfr_addr_i == `TMR_ADDR_MODE_SELECT) ##1
    (!sfr_wr_i && sfr_addr_i == `TMR_ADDR_MODE_SELECT)[*3] |-> sfr_rdata_o == $past(sfr_wdata_i, 3))
    else $error("mode register did not read back the written value");
  a_flag0_held: assert property ($fell(unit0_overflow_flag_o) |->
    $past(unit0_vector_ack_i) || $past(wr_ctrl)) else $error("unit 0 flag dropped by itself");
  a_flag1_held: assert property ($fell(unit1_overflow_flag_o) |->
    $past(unit1_vector_ack_i) || $past(wr_ctrl)) else $error("unit 1 flag dropped by itself");
  a_flag2_held: assert property ($fell(unit2_overflow_flag_o) |-> $past(wr_u2))
    else $error("unit 2 flag dropped without a write");
  a_flag0_in_ctrl: assert property (rd_ctrl[*3] |->
    sfr_rdata_o[`TMR_CTRL_U0_FLAG] == $past(unit0_overflow_flag_o))
    else $error("unit 0 flag port and control bit differ");
  a_flag1_in_ctrl: assert property (rd_ctrl[*3] |->
    sfr_rdata_o[`TMR_CTRL_U1_FLAG] == $past(unit1_overflow_flag_o))
    else $error("unit 1 flag port and control bit differ");
  a_flag2_in_ctrl: assert property (rd_u2[*3] |->
    sfr_rdata_o[`TMR_U2_FLAG] == $past(unit2_overflow_flag_o))
    else $error("unit 2 flag port and control bit differ");
  // reset has to be watched while it is asserted, so no disable here
  a_reset_clears_out: assert property (@(posedge ref_clk_i) disable iff (1'b0) rst_i |->
    {unit0_overflow_flag_o, unit1_overflow_flag_o, unit2_overflow_flag_o} == 3'h0)
    else $error("flags not cleared in reset");
endmodule

bind dual_mode_timer_counters timer_properties u_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
  .unit0_vector_ack_i(unit0_vector_ack_i), .unit1_vector_ack_i(unit1_vector_ack_i),
  .unit0_count_pin_i(unit0_count_pin_i), .unit1_count_pin_i(unit1_count_pin_i),
  .unit2_count_pin_i(unit2_count_pin_i), .ext_irq0_pin_i(ext_irq0_pin_i),
  .ext_irq1_pin_i(ext_irq1_pin_i), .unit0_overflow_flag_o(unit0_overflow_flag_o),
  .unit1_overflow_flag_o(unit1_overflow_flag_o), .unit2_overflow_flag_o(unit2_overflow_flag_o));
`default_nettype wire

// ==== dv/dual_mode_timer_counters_tb.sv ====
// self-checking bench for the timer/counter block
`timescale 1ns/1ps
`default_nettype none
`include "timer_consts.vh"

module dual_mode_timer_counters_tb;
  typedef struct packed {logic u; logic [7:0] mode, lo, hi, k, elo, ehi; logic ef;} tc_row;
  // unit, mode byte, presets, counts, expected bytes and flag
  tc_row rows [0:9] = '{
    '{1'b0, 8'h00, 8'hfe, 8'h00, 8'd3, 8'he1, 8'h01, 1'b0},
    '{1'b0, 8'h00, 8'h3f, 8'hff, 8'd1, 8'h20, 8'h00, 1'b1},
    '{1'b0, 8'h01, 8'hfe, 8'h12, 8'd3, 8'h01, 8'h13, 1'b0},
    '{1'b0, 8'h01, 8'hff, 8'hff, 8'd1, 8'h00, 8'h00, 1'b1},
    '{1'b0, 8'h02, 8'hff, 8'hfd, 8'd1, 8'hfd, 8'hfd, 1'b1},
    '{1'b1, 8'h00, 8'h1d, 8'h7f, 8'd4, 8'h01, 8'h80, 1'b0},
    '{1'b1, 8'h10, 8'hfe, 8'h34, 8'd2, 8'h00, 8'h35, 1'b0},
    '{1'b1, 8'h20, 8'hff, 8'h80, 8'd1, 8'h80, 8'h80, 1'b1},
    '{1'b1, 8'h30, 8'h55, 8'haa, 8'd5, 8'h55, 8'haa, 1'b0},
    '{1'b0, 8'h03, 8'hff, 8'h10, 8'd1, 8'h00, 8'h10, 1'b1}};
  logic       ref_clk_i = 1'b0;
  logic       rst_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic       sfr_wr_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [1:0] ack = 2'h0;
  logic [2:0] cnt_pin = 3'h0;
  logic [1:0] irq_pin = 2'h0;
  wire  [7:0] sfr_rdata_o;
  wire  [2:0] flag;
  int         n_errors = 0;
  int         compares = 0;

  dual_mode_timer_counters dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .unit0_vector_ack_i(ack[0]), .unit1_vector_ack_i(ack[1]),
    .unit0_count_pin_i(cnt_pin[0]), .unit1_count_pin_i(cnt_pin[1]),
    .unit2_count_pin_i(cnt_pin[2]), .ext_irq0_pin_i(irq_pin[0]), .ext_irq1_pin_i(irq_pin[1]),
    .unit0_overflow_flag_o(flag[0]), .unit1_overflow_flag_o(flag[1]),
    .unit2_overflow_flag_o(flag[2]));

  // 125 MHz core clock
  always #4 ref_clk_i = ~ref_clk_i;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  // strobe stays up so back-to-back writes never toggle it within one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic cyc(input int n);
    repeat (n) begin
      sfr_wr_i = 1'b0;
      @(posedge ref_clk_i);
      #1;
    end
  endtask
  // three edges so the registered read path has settled
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    sfr_wr_i = 1'b0;
    sfr_addr_i = a;
    repeat (3) @(posedge ref_clk_i);
    #1 chk(sfr_rdata_o, exp, msg);
  endtask
  // run bit set for exactly k counting edges
  task automatic run(input logic u, input int k);
    wr(`TMR_ADDR_CTRL_A, u ? 8'h40 : 8'h10);
    cyc(k - 1);
    wr(`TMR_ADDR_CTRL_A, 8'h00);
    sfr_wr_i = 1'b0;
  endtask
  task automatic cfg(input logic u, input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi);
    wr(`TMR_ADDR_MODE_SELECT, m);
    wr(`TMR_ADDR_CTRL_A, 8'h00);
    wr(`TMR_ADDR_U0_LOW + {7'h00, u}, lo);
    wr(`TMR_ADDR_U0_HIGH + {7'h00, u}, hi);
  endtask
  task automatic end_of_test;
    $display("compares %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // rise after time zero so the asynchronous reset branch sees an edge
    #1 rst_i = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    rd(`TMR_ADDR_MODE_SELECT, 8'h00, "mode reset");
    rd(`TMR_ADDR_CTRL_A, 8'h00, "ctrl reset");
    wr(`TMR_ADDR_MODE_SELECT, 8'h5a);
    rd(`TMR_ADDR_MODE_SELECT, 8'h5a, "mode readback");
    $display("test reset done");
    foreach (rows[i]) begin
      cfg(rows[i].u, rows[i].mode, rows[i].lo, rows[i].hi);
      run(rows[i].u, rows[i].k);
      chk({7'h00, flag[rows[i].u]}, {7'h00, rows[i].ef}, "flag port");
      rd(`TMR_ADDR_U0_LOW + {7'h00, rows[i].u}, rows[i].elo, "low byte");
      rd(`TMR_ADDR_U0_HIGH + {7'h00, rows[i].u}, rows[i].ehi, "high byte");
      rd(`TMR_ADDR_CTRL_A, {rows[i].ef, 7'h00} >> (rows[i].u ? 0 : 2), "ctrl flag");
      $display("test row %0d done", i);
    end
    for (int u = 0; u < 2; u++) begin
      // gated by a low interrupt pin, then free with it high
      irq_pin = 2'h0;
      cfg(u[0], 8'h09 << (4 * u), 8'h00, 8'h00);
      run(u[0], 5);
      rd(`TMR_ADDR_U0_LOW + u[7:0], 8'h00, "gated off");
      irq_pin[u] = 1'b1;
      cyc(4);
      run(u[0], 5);
      rd(`TMR_ADDR_U0_LOW + u[7:0], 8'h05, "gated on");
      // pin events at the highest legal rate, one cycle per level
      cfg(u[0], 8'h05 << (4 * u), 8'h00, 8'h00);
      wr(`TMR_ADDR_CTRL_A, u ? 8'h40 : 8'h10);
      repeat (4) begin
        cnt_pin[u] = 1'b1;
        cyc(1);
        cnt_pin[u] = 1'b0;
        cyc(1);
      end
      cyc(6);
      wr(`TMR_ADDR_CTRL_A, 8'h00);
      rd(`TMR_ADDR_U0_LOW + u[7:0], 8'h04, "pin events");
      // overflow flag cleared by the vector acknowledge
      cfg(u[0], 8'h01 << (4 * u), 8'hff, 8'hff);
      run(u[0], 1);
      chk({7'h00, flag[u]}, 8'h01, "flag before ack");
      ack[u] = 1'b1;
      cyc(1);
      ack[u] = 1'b0;
      cyc(1);
      chk({7'h00, flag[u]}, 8'h00, "flag after ack");
      $display("test unit %0d pins done", u);
    end
    // split unit 0: high byte runs on the unit-1 run bit and owns the unit-1 flag
    cfg(1'b0, 8'h03, 8'h00, 8'hfe);
    run(1'b1, 2);
    chk({7'h00, flag[1]}, 8'h01, "split high flag");
    rd(`TMR_ADDR_U0_HIGH, 8'h00, "split high byte");
    rd(`TMR_ADDR_U0_LOW, 8'h00, "split low byte");
    rd(`TMR_ADDR_CTRL_A, 8'h80, "split ctrl flag");
    $display("test split done");
    wr(`TMR_ADDR_U2_CONTROL, 8'h00);
    wr(`TMR_ADDR_U2_LOW, 8'h5a);
    rd(`TMR_ADDR_U2_LOW, 8'h5a, "unit 2 low");
    rd(8'hc9, 8'h00, "unmapped read");
    // unit 2 wraps into its reload pair; the set beats the clearing write
    wr(`TMR_ADDR_U2_RELOAD_LOW, 8'h34);
    wr(`TMR_ADDR_U2_RELOAD_HI, 8'h12);
    wr(`TMR_ADDR_U2_HIGH, 8'hff);
    wr(`TMR_ADDR_U2_LOW, 8'hfe);
    wr(`TMR_ADDR_U2_CONTROL, 8'h04);
    cyc(1);
    wr(`TMR_ADDR_U2_CONTROL, 8'h00);
    sfr_wr_i = 1'b0;
    chk({7'h00, flag[2]}, 8'h01, "unit 2 flag");
    rd(`TMR_ADDR_U2_LOW, 8'h34, "unit 2 reload low");
    rd(`TMR_ADDR_U2_HIGH, 8'h12, "unit 2 reload high");
    rd(`TMR_ADDR_U2_CONTROL, 8'h80, "unit 2 ctrl flag");
    wr(`TMR_ADDR_U2_CONTROL, 8'h00);
    cyc(1);
    chk({7'h00, flag[2]}, 8'h00, "unit 2 flag cleared");
    $display("test unit 2 done");
    // second reset in mid-run clears counters and mode
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    rd(`TMR_ADDR_U2_LOW, 8'h00, "unit 2 low after reset");
    rd(`TMR_ADDR_U2_RELOAD_LOW, 8'h00, "reload after reset");
    rd(`TMR_ADDR_MODE_SELECT, 8'h00, "mode after reset");
    $display("test mid reset done");
    end_of_test();
  end

  // far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
